// file: core/bus_idle_timer.sv
// timer that reports a suspend after a long idle bus
`timescale 1ns/1ps
module bus_idle_timer #(
    parameter int IDLE_CYCLES = usb_glob_pkg::SUSPEND_CYCLES
) (
    input wire logic clk_i,  // system clock
    input wire logic rst_i,  // synchronous reset, high
    input wire logic idle_i, // bus idle in j state
    output logic done_o      // one pulse when idle lasted long enough
);

    usb_glob_pkg::idle_state_type state;
    logic [usb_glob_pkg::TIMER_W-1:0] count;
    logic last_tick;

    assign last_tick = (count == usb_glob_pkg::TIMER_W'(IDLE_CYCLES - 1));

    // ------------------------------------------------------------
    // state and counter
    // ------------------------------------------------------------
    // any non-idle cycle restarts the count from zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !idle_i) begin
            state <= usb_glob_pkg::IDLE_WAIT;
            count <= '0;
        end else begin
            unique case (state)
                usb_glob_pkg::IDLE_WAIT: begin
                    state <= usb_glob_pkg::IDLE_COUNT;
                    count <= usb_glob_pkg::TIMER_W'(1);
                end
                usb_glob_pkg::IDLE_COUNT: begin
                    if (last_tick) begin
                        state <= usb_glob_pkg::IDLE_DONE;
                    end
                    count <= count + usb_glob_pkg::TIMER_W'(1);
                end
                usb_glob_pkg::IDLE_DONE: begin
                    state <= usb_glob_pkg::IDLE_DONE;
                end
                default: begin
                    state <= usb_glob_pkg::IDLE_WAIT;
                end
            endcase
        end
    end

    // pulse once on entering the done state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= idle_i && last_tick
                      && (state == usb_glob_pkg::IDLE_COUNT);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_idle_done_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_o |-> $past(count) == usb_glob_pkg::TIMER_W'(IDLE_CYCLES - 1))
        else $error("suspend reported before idle time elapsed");

endmodule // bus_idle_timer

// file: core/usb_global_event.sv
// usb global events, interrupt enables and function address
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module usb_global_event #(
    parameter int SUSPEND_CYCLES = usb_glob_pkg::SUSPEND_CYCLES
) (
    input wire logic clk_i,                         // system clock
    input wire logic rst_i,                         // sync reset, high
    input wire logic cyc_i,                         // wishbone cycle
    input wire logic stb_i,                         // wishbone strobe
    input wire logic we_i,                          // wishbone write
    input wire logic [usb_glob_pkg::ADR_W-1:0] adr_i, // byte address
    input wire logic [3:0] sel_i,                   // byte lanes
    input wire logic [usb_glob_pkg::DAT_W-1:0] dat_i, // write data
    output logic [usb_glob_pkg::DAT_W-1:0] dat_o,   // read data
    output logic ack_o,                             // wishbone ack
    input wire usb_glob_pkg::bus_events_type events_i, // bus detector
    output logic usb_irq_o,                         // interrupt, high
    output logic function_enable_o,                 // usb function on
    output logic [6:0] device_address_o             // device address
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] flags;
    logic [7:0] enables;
    usb_glob_pkg::func_address_type func_addr;
    logic [7:0] next_flags;
    logic [7:0] set_bits;
    logic [7:0] clear_bits;
    logic [7:0] read_byte;
    logic regs_reset;
    logic bus_req;
    logic wr_fire;
    logic wr_flags_clear;
    logic wr_enables;
    logic wr_address;
    logic suspend_done;
    logic wake_event;
    logic rd_event_word;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // true when the byte address selects the word of a register index
    function automatic logic reg_hit(
        input logic [usb_glob_pkg::ADR_W-1:0] adr,
        input logic [7:0] idx
    );
        reg_hit = (adr[usb_glob_pkg::ADR_W-1:10] == '0)
                  && (adr[9:2] == idx);
    endfunction

    // keep only the four implemented event positions
    function automatic logic [7:0] event_bits(input logic [7:0] value);
        event_bits = value & usb_glob_pkg::EVENT_MASK;
    endfunction

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    // system reset or a bus reset brings the enables, the address and the idle timer back
    assign regs_reset = rst_i || events_i.bus_reset;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign bus_req = cyc_i && stb_i;
    // a write takes effect on the edge where ack is sampled high
    assign wr_fire = bus_req && we_i && ack_o && sel_i[0];
    assign wr_flags_clear = wr_fire
        && reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_CLEAR);
    assign wr_enables = wr_fire
        && reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_ENABLES);
    assign wr_address = wr_fire
        && reg_hit(adr_i, usb_glob_pkg::IDX_FUNC_ADDRESS);

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req && !ack_o;
        end
    end

    // read mux; unmapped and write-only words read as zero
    always_comb begin
        read_byte = 8'h00;
        if (reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_FLAGS)) begin
            read_byte = event_bits(flags);
        end else if (reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_ENABLES)) begin
            read_byte = event_bits(enables);
        end else if (reg_hit(adr_i, usb_glob_pkg::IDX_FUNC_ADDRESS)) begin
            read_byte = func_addr;
        end
    end

    // the two event words, for the reserved-bit check on reads
    assign rd_event_word = reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_FLAGS)
        || reg_hit(adr_i, usb_glob_pkg::IDX_EVENT_ENABLES);

    // read data captured as the request is taken, valid with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (bus_req && !ack_o) begin
            dat_o <= {24'h00_0000, read_byte};
        end
    end

    // ------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------
    // wake only from line activity, never from our own resume
    assign wake_event = events_i.suspended && events_i.line_nonidle
                        && !events_i.upstream_resume;

    // idle bus timer for suspend detection
    bus_idle_timer #(
        .IDLE_CYCLES(SUSPEND_CYCLES)
    ) idle_timer (
        .clk_i(clk_i),
        .rst_i(regs_reset),
        .idle_i(events_i.idle_j),
        .done_o(suspend_done)
    );

    // events that set flags this cycle
    always_comb begin
        set_bits = 8'h00;
        set_bits[usb_glob_pkg::BIT_WAKE] = wake_event;
        set_bits[usb_glob_pkg::BIT_RESET_END] = events_i.reset_end;
        set_bits[usb_glob_pkg::BIT_FRAME_START] = events_i.sof_pid;
        set_bits[usb_glob_pkg::BIT_SUSPEND] = suspend_done;
    end

    // software clears by writing ones to the clear word
    assign clear_bits = wr_flags_clear ? event_bits(dat_i[7:0]) : 8'h00;

    // ------------------------------------------------------------
    // event flag register
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle; flags are sticky
    assign next_flags = event_bits((flags & ~clear_bits) | set_bits);

    // a reset-end pulse coincident with bus reset still survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= usb_glob_pkg::FLAGS_RESET;
        end else if (events_i.bus_reset) begin
            flags <= usb_glob_pkg::FLAGS_RESET | set_bits;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------
    // only the four enable positions are stored
    always_ff @(posedge clk_i) begin
        if (regs_reset) begin
            enables <= usb_glob_pkg::ENABLES_RESET;
        end else if (wr_enables) begin
            enables <= event_bits(dat_i[7:0]);
        end
    end

    // ------------------------------------------------------------
    // function address register
    // ------------------------------------------------------------
    // function on and address zero after any reset
    always_ff @(posedge clk_i) begin
        if (regs_reset) begin
            func_addr <= usb_glob_pkg::ADDRESS_RESET;
        end else if (wr_address) begin
            func_addr <= dat_i[7:0];
        end
    end

    assign function_enable_o = func_addr.function_enable;
    assign device_address_o = func_addr.device_address_field;

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // level request while any enabled flag is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_irq_o <= 1'b0;
        end else begin
            usb_irq_o <= |(flags & enables);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a request is answered exactly one cycle later, for one cycle
    sequence s_request_taken;
        bus_req && !ack_o;
    endsequence

    sequence s_ack_once;
        ack_o ##1 !ack_o;
    endsequence

    a_bus_ack_timing: assert property (
        s_request_taken |=> s_ack_once)
        else $error("ack did not follow request by one cycle");

    a_wake_sets_flag: assert property (
        wake_event |=> flags[usb_glob_pkg::BIT_WAKE])
        else $error("wake event did not set its flag");

    a_wake_from_line: assert property (
        $rose(flags[usb_glob_pkg::BIT_WAKE])
        |-> $past(events_i.suspended) && !$past(events_i.upstream_resume))
        else $error("wake flag set outside suspend or by own resume");

    a_reset_end_flag: assert property (
        events_i.reset_end |=> flags[usb_glob_pkg::BIT_RESET_END])
        else $error("end of reset did not set its flag");

    a_reset_end_sticky: assert property (
        flags[usb_glob_pkg::BIT_RESET_END] && !wr_flags_clear
        && !events_i.bus_reset |=> flags[usb_glob_pkg::BIT_RESET_END])
        else $error("end of reset flag dropped without a clear");

    a_frame_flag: assert property (
        events_i.sof_pid |=> flags[usb_glob_pkg::BIT_FRAME_START])
        else $error("start of frame did not set its flag");

    a_suspend_flag: assert property (
        suspend_done && !events_i.bus_reset
        |=> flags[usb_glob_pkg::BIT_SUSPEND])
        else $error("idle timeout did not set suspend flag");

    a_irq_masking: assert property (
        ##1 usb_irq_o == $past(|(flags & enables)))
        else $error("interrupt does not follow enabled flags");

    a_reserved_zero: assert property (
        ack_o && !we_i && $past(rd_event_word)
        |-> (dat_o[7:6] == 2'b00) && (dat_o[2:1] == 2'b00))
        else $error("reserved bits read as nonzero");

    a_enables_reset: assert property (
        $past(events_i.bus_reset) |-> enables == usb_glob_pkg::ENABLES_RESET)
        else $error("enables not at reset value after bus reset");

    a_address_reset: assert property (
        $past(events_i.bus_reset)
        |-> func_addr == usb_glob_pkg::ADDRESS_RESET)
        else $error("address register not reset by bus reset");

    a_address_write: assert property (
        wr_address && !events_i.bus_reset
        |=> func_addr == $past(dat_i[7:0]))
        else $error("address write did not take effect");

    a_flags_clear: assert property (
        wr_flags_clear && !events_i.bus_reset
        && !set_bits[usb_glob_pkg::BIT_FRAME_START]
        && dat_i[usb_glob_pkg::BIT_FRAME_START]
        |=> !flags[usb_glob_pkg::BIT_FRAME_START])
        else $error("frame flag not cleared by software");

    // ------------------------------------------------------------
    // register contents and reset values
    // ------------------------------------------------------------
    // reserved positions never hold a one in either event word
    a_flags_reserved: assert property (
        (flags & ~usb_glob_pkg::EVENT_MASK) == 8'h00)
        else $error("reserved flag bit set");

    a_enables_reserved: assert property (
        (enables & ~usb_glob_pkg::EVENT_MASK) == 8'h00)
        else $error("reserved enable bit set");

    // first cycle out of system reset shows every reset value
    a_flags_after_reset: assert property (
        $past(rst_i) |-> flags == usb_glob_pkg::FLAGS_RESET)
        else $error("event flags not zero after reset");

    a_enables_after_reset: assert property (
        $past(rst_i) |-> enables == usb_glob_pkg::ENABLES_RESET)
        else $error("enables not at reset value after reset");

    a_address_after_reset: assert property (
        $past(rst_i) |-> func_addr == usb_glob_pkg::ADDRESS_RESET)
        else $error("address register not at reset value");

    // a bus reset keeps only the events of its own last cycle
    a_bus_reset_flags: assert property (
        $past(events_i.bus_reset) && !$past(rst_i)
        |-> flags == $past(set_bits))
        else $error("bus reset did not clear the event flags");

    // a software write stores only the four enable positions
    a_enables_write: assert property (
        wr_enables && !events_i.bus_reset
        |=> enables == event_bits($past(dat_i[7:0])))
        else $error("enable write did not take effect");

    // a write with lane zero off changes no register
    a_lane_off_write: assert property (
        bus_req && we_i && ack_o && !sel_i[0] && !events_i.bus_reset
        |=> $stable(enables) && $stable(func_addr))
        else $error("write with lane zero off changed a register");

    // the idle timer reports once per idle period
    a_suspend_single: assert property (
        suspend_done |=> !suspend_done)
        else $error("suspend reported twice in a row");

    // an enabled start of frame raises the request two edges later
    sequence s_enabled_frame;
        events_i.sof_pid && enables[usb_glob_pkg::BIT_FRAME_START]
        && !events_i.bus_reset && !wr_enables;
    endsequence

    a_frame_irq: assert property (
        s_enabled_frame |=> ##1 usb_irq_o)
        else $error("enabled start of frame raised no interrupt");

endmodule // usb_global_event

// file: pkg/usb_glob_pkg.sv
// constants and carrier types for the usb global event and address block
package usb_glob_pkg;

    // ------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_EVENT_FLAGS = 8'hBD;
    localparam logic [7:0] IDX_EVENT_ENABLES = 8'hBE;
    localparam logic [7:0] IDX_EVENT_CLEAR = 8'hBF;
    localparam logic [7:0] IDX_FUNC_ADDRESS = 8'hC6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_WAKE = 5;
    localparam int BIT_RESET_END = 4;
    localparam int BIT_FRAME_START = 3;
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_FUNC_ENABLE = 7;
    localparam logic [7:0] EVENT_MASK = 8'h39;
    localparam logic [7:0] ADDRESS_MASK = 8'h7F;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h10;
    localparam logic [7:0] ADDRESS_RESET = 8'h80;

    // ------------------------------------------------------------
    // timing: idle bus for three frames before suspend
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int SUSPEND_IDLE_US = 3000;
    localparam int SUSPEND_CYCLES = (SUSPEND_IDLE_US * CLK_FREQ_KHZ + 999)
                                    / 1000;
    localparam int TIMER_W = 18;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    // levels and pulses from the bus-event detector
    typedef struct packed {
        logic suspended;       // controller is in suspend state
        logic line_nonidle;    // non-idle signal seen on the line
        logic upstream_resume; // resume driven by this device
        logic bus_reset;       // reset condition present on the bus
        logic reset_end;       // end of bus reset detected, pulse
        logic sof_pid;         // start of frame pid detected, pulse
        logic idle_j;          // bus idle in j state
    } bus_events_type;

    // function address register contents
    typedef struct packed {
        logic function_enable;
        logic [6:0] device_address_field;
    } func_address_type;

    // idle timer states, gray coded along the usual path
    typedef enum logic [1:0] {
        IDLE_WAIT = 2'b00,
        IDLE_COUNT = 2'b01,
        IDLE_DONE = 2'b11
    } idle_state_type;

endpackage

// file: verif/test_usb_global_event.sv
// register-level bench for the usb global event and address block
`timescale 1ns/1ps
module test_usb_global_event;
    localparam int SC = 20;
    localparam int LIMIT = 5000;
    localparam logic [7:0] FLG = usb_glob_pkg::IDX_EVENT_FLAGS;
    localparam logic [7:0] ENA = usb_glob_pkg::IDX_EVENT_ENABLES;
    localparam logic [7:0] CLR = usb_glob_pkg::IDX_EVENT_CLEAR;
    localparam logic [7:0] ADR = usb_glob_pkg::IDX_FUNC_ADDRESS;

    logic clk_i = 1'b0;
    logic rst_i, cyc_i, stb_i, we_i;
    logic [usb_glob_pkg::ADR_W-1:0] adr_i;
    logic [3:0] sel_i;
    logic [usb_glob_pkg::DAT_W-1:0] dat_i, dat_o;
    logic ack_o, usb_irq_o, function_enable_o;
    logic [6:0] device_address_o;
    usb_glob_pkg::bus_events_type events_i;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // clock, design and line model
    // ------------------------------------------------------------
    always #10 clk_i = ~clk_i;

    usb_global_event #(.SUSPEND_CYCLES(SC)) u_usb_global_event (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .events_i(events_i),
        .usb_irq_o(usb_irq_o), .function_enable_o(function_enable_o),
        .device_address_o(device_address_o)
    );

    usb_bus_model u_usb_bus_model (.clk_i(clk_i), .events_o(events_i));

    // ------------------------------------------------------------
    // comparison, verdict and hang guard
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // stuck bench counts as a mismatch
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // wishbone classic master
    // ------------------------------------------------------------
    // wait for ack, only the hang guard bounds it; release at the ack edge
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        // one edge takes the request, ack stands at the next
        check(32'(n), 32'h0000_0002);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= 1'b1;
        adr_i <= {2'b00, i, 2'b00};
        dat_i <= {24'h00_0000, d};
        sel_i <= s;
        wait_ack();
    endtask

    // read a register and compare with the expected byte
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        adr_i <= {2'b00, i, 2'b00};
        wait_ack();
        check(dat_o, {24'h00_0000, e});
    endtask

    task automatic irq(input logic e);
        check(32'(usb_irq_o), 32'(e));
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = '0;
        sel_i = 4'h0;
        dat_i = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // values after reset
        rc(FLG, 8'h00);
        rc(ENA, 8'h10);
        rc(ADR, 8'h80);
        check(32'(function_enable_o), 32'h0000_0001);
        check(32'(device_address_o), 32'h0000_0000);
        irq(1'b0);
        // layout, reserved bits, read-only and refused writes
        wr(ENA, 8'hFF, 4'hF);
        rc(ENA, 8'h39);
        wr(ADR, 8'h05, 4'h1);
        rc(ADR, 8'h05);
        check(32'(device_address_o), 32'h0000_0005);
        check(32'(function_enable_o), 32'h0000_0000);
        wr(ADR, 8'h85, 4'h0);
        rc(ADR, 8'h05);
        wr(FLG, 8'hFF, 4'hF);
        rc(FLG, 8'h00);
        rc(8'h10, 8'h00);
        wr(ADR, 8'h85, 4'h1);
        // start of frame, then masked start of frame
        u_usb_bus_model.send_sof();
        rc(FLG, 8'h08);
        irq(1'b1);
        wr(CLR, 8'h08, 4'h1);
        rc(FLG, 8'h00);
        irq(1'b0);
        wr(ENA, 8'h31, 4'h1);
        u_usb_bus_model.send_sof();
        rc(FLG, 8'h08);
        irq(1'b0);
        wr(ENA, 8'h39, 4'h1);
        rc(ENA, 8'h39);
        irq(1'b1);
        wr(CLR, 8'h08, 4'h1);
        // wake: own resume ignored, line activity flagged
        u_usb_bus_model.line_wake(1'b1);
        rc(FLG, 8'h00);
        u_usb_bus_model.line_wake(1'b0);
        rc(FLG, 8'h20);
        irq(1'b1);
        // usb clocks are taken as running before the wake clear
        wr(CLR, 8'h20, 4'h1);
        // broken idle spans do not suspend, a full one does
        u_usb_bus_model.idle(SC / 2);
        u_usb_bus_model.idle(SC / 2);
        rc(FLG, 8'h00);
        u_usb_bus_model.idle(SC + 4);
        rc(FLG, 8'h01);
        irq(1'b1);
        // suspend flag cleared before any power down
        wr(CLR, 8'h01, 4'h1);
        rc(FLG, 8'h00);
        // bus reset restores registers and drops the pending frame flag
        u_usb_bus_model.send_sof();
        u_usb_bus_model.bus_reset(3);
        rc(FLG, 8'h10);
        rc(ENA, 8'h10);
        rc(ADR, 8'h80);
        check(32'(function_enable_o), 32'h0000_0001);
        check(32'(device_address_o), 32'h0000_0000);
        rc(FLG, 8'h10);
        irq(1'b1);
        wr(CLR, 8'h10, 4'h1);
        rc(FLG, 8'h00);
        irq(1'b0);
        print_verdict();
    end
endmodule // test_usb_global_event

// file: verif/usb_bus_model.sv
// stand-in for the usb line and host, seen through the event detector
`timescale 1ns/1ps
module usb_bus_model (
    input wire logic clk_i,                        // system clock
    output usb_glob_pkg::bus_events_type events_o  // detector outputs
);
    // ------------------------------------------------------------
    // quiet line at start
    // ------------------------------------------------------------
    initial begin
        events_o = '0;
    end

    // ------------------------------------------------------------
    // event tasks, each starts one edge after the last change
    // ------------------------------------------------------------
    // one start-of-frame pid pulse
    task automatic send_sof();
        @(posedge clk_i);
        events_o.sof_pid <= 1'b1;
        @(posedge clk_i);
        events_o.sof_pid <= 1'b0;
    endtask

    // line activity while suspended; own marks our upstream resume
    task automatic line_wake(input logic own);
        @(posedge clk_i);
        events_o.suspended <= 1'b1;
        events_o.line_nonidle <= 1'b1;
        events_o.upstream_resume <= own;
        @(posedge clk_i);
        events_o.suspended <= 1'b0;
        events_o.line_nonidle <= 1'b0;
        events_o.upstream_resume <= 1'b0;
    endtask

    // reset held on the bus, then the end-of-reset pulse
    task automatic bus_reset(input int n);
        @(posedge clk_i);
        events_o.bus_reset <= 1'b1;
        repeat (n) @(posedge clk_i);
        events_o.bus_reset <= 1'b0;
        events_o.reset_end <= 1'b1;
        @(posedge clk_i);
        events_o.reset_end <= 1'b0;
    endtask

    // bus idle in j state for n cycles, then activity
    task automatic idle(input int n);
        @(posedge clk_i);
        events_o.idle_j <= 1'b1;
        repeat (n) @(posedge clk_i);
        events_o.idle_j <= 1'b0;
    endtask
endmodule // usb_bus_model
